// [verilog/ivp_pkg.sv]
// Package: interrupt numbers, vector offsets, priority ranks and helper functions
package ivp_pkg;

    localparam int IVP_NUM_IRQS = 32;
    localparam int IVP_NUM_W = 5;
    localparam int IVP_ADDR_W = 24;
    localparam int IVP_RANK_W = 5;

    // Vector step in bytes, as a left shift
    localparam int IVP_VEC_SHIFT = 3;

    // Interrupt numbers with a named source, the high-group bounds and the unassigned number
    localparam logic [4:0] IVP_NUM_RESET = 5'h00;
    localparam logic [4:0] IVP_NUM_EXT_IRQ_A = 5'h02;
    localparam logic [4:0] IVP_NUM_EXT_IRQ_B = 5'h03;
    localparam logic [4:0] IVP_NUM_TIMER_AGG = 5'h04;
    localparam logic [4:0] IVP_NUM_SHARED_TX_P0 = 5'h05;
    localparam logic [4:0] IVP_NUM_SHARED_RX_P0 = 5'h07;
    localparam logic [4:0] IVP_NUM_SHARED_TX_P1 = 5'h09;
    localparam logic [4:0] IVP_NUM_SHARED_RX_P1 = 5'h0B;
    localparam logic [4:0] IVP_NUM_CONV_DONE = 5'h0D;
    localparam logic [4:0] IVP_NUM_HIGH_FIRST = 5'h10;
    localparam logic [4:0] IVP_NUM_WAKEUP_RTC = 5'h12;
    localparam logic [4:0] IVP_NUM_HIGH_LAST = 5'h17;
    localparam logic [4:0] IVP_NUM_NO_SOURCE = 5'h16;
    localparam logic [4:0] IVP_NUM_BUS_FAULT = 5'h18;
    localparam logic [4:0] IVP_NUM_DATA_LOGGING = 5'h19;
    localparam logic [4:0] IVP_NUM_RTOS = 5'h1A;

    // Relative vector offsets in bytes
    localparam logic [23:0] IVP_OFS_RESET = 24'h000000;
    localparam logic [23:0] IVP_OFS_EXT_IRQ_A = 24'h000010;
    localparam logic [23:0] IVP_OFS_EXT_IRQ_B = 24'h000018;
    localparam logic [23:0] IVP_OFS_SHARED_TX_P0 = 24'h000028;
    localparam logic [23:0] IVP_OFS_SHARED_RX_P0 = 24'h000038;
    localparam logic [23:0] IVP_OFS_SHARED_TX_P1 = 24'h000048;
    localparam logic [23:0] IVP_OFS_SHARED_RX_P1 = 24'h000058;
    localparam logic [23:0] IVP_OFS_CONV_DONE = 24'h000068;
    localparam logic [23:0] IVP_OFS_WAKEUP_RTC = 24'h000090;
    localparam logic [23:0] IVP_OFS_RTOS = 24'h0000D0;
    localparam logic [23:0] IVP_OFS_LAST = 24'h0000F8;

    // Named priority ranks
    localparam logic [4:0] IVP_RK_RESET = 5'h00;
    localparam logic [4:0] IVP_RK_EXT_IRQ_A = 5'h03;
    localparam logic [4:0] IVP_RK_EXT_IRQ_B = 5'h05;
    localparam logic [4:0] IVP_RK_SHARED_TX_P0 = 5'h07;
    localparam logic [4:0] IVP_RK_SHARED_RX_P0 = 5'h0A;
    localparam logic [4:0] IVP_RK_SHARED_TX_P1 = 5'h0D;
    localparam logic [4:0] IVP_RK_SHARED_RX_P1 = 5'h0F;
    localparam logic [4:0] IVP_RK_CONV_DONE = 5'h12;
    localparam logic [4:0] IVP_RK_WAKEUP_RTC = 5'h0C;
    localparam logic [4:0] IVP_RK_RTOS = 5'h1A;
    localparam logic [4:0] IVP_RK_NONE = 5'h1F;

    // Rank of each interrupt number, index is the number
    localparam logic [4:0] IVP_RANK [32] = '{
        IVP_RK_RESET,
        5'h01,
        IVP_RK_EXT_IRQ_A,
        IVP_RK_EXT_IRQ_B,
        5'h06,
        IVP_RK_SHARED_TX_P0,
        5'h09,
        IVP_RK_SHARED_RX_P0,
        5'h0B,
        IVP_RK_SHARED_TX_P1,
        5'h0E,
        IVP_RK_SHARED_RX_P1,
        5'h11,
        IVP_RK_CONV_DONE,
        5'h15,
        5'h16,
        5'h04,
        5'h08,
        IVP_RK_WAKEUP_RTC,
        5'h10,
        5'h13,
        5'h14,
        IVP_RK_NONE,
        5'h18,
        5'h02,
        5'h19,
        IVP_RK_RTOS,
        5'h0E,
        5'h0F,
        5'h10,
        5'h11,
        5'h12
    };

    // Numbers 16 to 23 use the high-group base
    function automatic logic ivp_is_high(input logic [4:0] n);
        return (n >= IVP_NUM_HIGH_FIRST) && (n <= IVP_NUM_HIGH_LAST);
    endfunction : ivp_is_high

    // Byte offset of a vector: eight bytes per number
    function automatic logic [23:0] ivp_offset(input logic [4:0] n);
        return {16'h0000, n, 3'h0};
    endfunction : ivp_offset

    // Absolute vector address
    function automatic logic [23:0] ivp_vector(input logic [4:0] n,
        input logic [23:0] lo, input logic [23:0] hi);
        return (ivp_is_high(n) ? hi : lo) + ivp_offset(n);
    endfunction : ivp_vector

endpackage : ivp_pkg

// [verilog/ivp_rank_sel.sv]
// Picks the candidate with the smallest priority rank
module ivp_rank_sel
    import ivp_pkg::*;
(
    // Candidates
    input wire logic [31:0] cand,
    // Winner
    output logic sel_any,
    output logic [4:0] sel_num,
    output logic [4:0] sel_rank
);

    always_comb
    begin
        sel_any = 1'b0;
        sel_num = 5'h00;
        sel_rank = IVP_RK_NONE;
        for (int i = 0; i < IVP_NUM_IRQS; i++)
        begin
            // Strict compare keeps the lower number on equal ranks
            if (cand[i] && (!sel_any || (IVP_RANK[i] < sel_rank)))
            begin
                sel_any = 1'b1;
                sel_num = 5'(i);
                sel_rank = IVP_RANK[i];
            end
        end
    end

endmodule : ivp_rank_sel

// [verilog/ivp_map.sv]
// Interrupt vector and priority mapper facing the processor core
// Function
// - Vector offset of interrupt n is eight bytes times n.
// - Each interrupt has a fixed priority rank from a table, 0 to 26, except number 22 at rank 31.
// - Numbers 0-15 and 24-31 add their offset to the low-group base.
// - Numbers 16-23 add their offset to the high-group base.
// - Reset is number 0, offset zero, rank 0.
// - External user interrupt A is number 2, offset 0x10, rank 3.
// - External user interrupt B is number 3, offset 0x18, rank 5.
// - Shared transmit port 0 is number 5, offset 0x28, rank 7.
// - Shared receive port 0 is number 7, offset 0x38, rank 10.
// - Shared transmit port 1 is number 9, offset 0x48, rank 13.
// - Shared receive port 1 is number 11, offset 0x58, rank 15.
// - Conversion done is number 13, offset 0x68, rank 18.
// - Wakeup or clock is number 18, offset 0x90, rank 12, high base.
// - Operating system interrupt is number 26, offset 0xD0, rank 26.
module ivp_map
    import ivp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // Interrupt sources
    input wire logic [31:0] hw_irq_req,
    input wire logic [31:0] irq_enable,
    // Software traps
    input wire logic sw_trap_valid,
    input wire logic [4:0] software_trap_number,
    // Vector base pointers
    input wire logic [23:0] vector_base_low_group,
    input wire logic [23:0] vector_base_high_group,
    // Core side
    output logic irq_valid,
    input wire logic irq_ack,
    output logic [4:0] irq_number,
    output logic [4:0] irq_rank,
    output logic [23:0] irq_vector_addr
);

    typedef enum logic {
        IVP_IDLE,
        IVP_OFFER
    } ivp_state_t;

    typedef struct packed {
        ivp_state_t st;
        logic [31:0] pend;
        logic [31:0] swp;
        logic [4:0] num;
        logic [4:0] rank;
        logic [23:0] vec;
    } ivp_regs_t;

    localparam logic [31:0] IVP_ONE = 32'h00000001;
    localparam logic [31:0] IVP_NO_SRC_MASK = IVP_ONE << IVP_NUM_NO_SOURCE;
    localparam logic [31:0] IVP_UNMASKABLE = IVP_ONE << IVP_NUM_RESET;

    ivp_regs_t r_q;
    ivp_regs_t r_d;
    logic [31:0] hw_set;
    logic [31:0] sw_set;
    logic [31:0] clr;
    logic [31:0] cand;
    logic sel_any;
    logic [4:0] sel_num;
    logic [4:0] sel_rank;
    logic take;

    // Hardware requests, number 22 dropped
    assign hw_set = hw_irq_req & ~IVP_NO_SRC_MASK;
    assign sw_set = sw_trap_valid ? (IVP_ONE << software_trap_number) : 32'h00000000;
    assign clr = (irq_valid && irq_ack) ? (IVP_ONE << r_q.num) : 32'h00000000;

    // Reset request cannot be masked; traps bypass the enables
    assign cand = (r_q.pend & (irq_enable | IVP_UNMASKABLE)) | r_q.swp;

    ivp_rank_sel u_sel (
        .cand(cand),
        .sel_any(sel_any),
        .sel_num(sel_num),
        .sel_rank(sel_rank)
    );

    assign take = ce && (r_q.st == IVP_IDLE) && sel_any;

    always_comb
    begin
        r_d = r_q;
        // Clear first so a new event in the same cycle survives
        r_d.pend = (r_q.pend & ~clr) | hw_set | sw_set;
        r_d.swp = (r_q.swp & ~clr) | sw_set;
        unique case (r_q.st)
            IVP_IDLE:
            begin
                if (sel_any)
                begin
                    r_d.st = IVP_OFFER;
                    r_d.num = sel_num;
                    r_d.rank = sel_rank;
                    r_d.vec = ivp_vector(sel_num, vector_base_low_group,
                        vector_base_high_group);
                end
            end
            IVP_OFFER:
            begin
                if (irq_ack)
                begin
                    r_d.st = IVP_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            r_q <= '{st: IVP_IDLE, pend: 32'h00000000, swp: 32'h00000000,
                num: 5'h00, rank: 5'h00, vec: 24'h000000};
        end
        else if (ce)
        begin
            r_q <= r_d;
        end
    end

    assign irq_valid = (r_q.st == IVP_OFFER);
    assign irq_number = r_q.num;
    assign irq_rank = r_q.rank;
    assign irq_vector_addr = r_q.vec;

    // Checker helper: some candidate has a smaller rank than the winner
    logic outranked;
    always_comb
    begin
        outranked = 1'b0;
        for (int i = 0; i < IVP_NUM_IRQS; i++)
        begin
            if (cand[i] && (IVP_RANK[i] < sel_rank))
            begin
                outranked = 1'b1;
            end
        end
    end

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence s_take_num(logic [4:0] n);
        take && (sel_num == n);
    endsequence

    sequence s_offer_map(logic [4:0] n, logic [4:0] k, logic [23:0] addr);
        irq_valid && (irq_number == n) && (irq_rank == k) && (irq_vector_addr == addr);
    endsequence

    sequence s_ack_edge;
        irq_valid && irq_ack && ce;
    endsequence

    property p_map_low(logic [4:0] n, logic [4:0] k, logic [23:0] ofs);
        s_take_num(n) |=> s_offer_map(n, k, $past(vector_base_low_group) + ofs);
    endproperty

    property p_map_high(logic [4:0] n, logic [4:0] k, logic [23:0] ofs);
        s_take_num(n) |=> s_offer_map(n, k, $past(vector_base_high_group) + ofs);
    endproperty

    chk_take_offers_winner: assert property (
        take |=> irq_valid && (irq_number == $past(sel_num)) && (irq_rank == $past(sel_rank)))
        else $error("offer does not match selected winner");

    chk_winner_min_rank: assert property (
        take |-> !outranked && cand[sel_num])
        else $error("a candidate with a smaller rank was passed over");

    chk_reset_first: assert property (
        take && cand[IVP_NUM_RESET]
        |=> s_offer_map(IVP_NUM_RESET, IVP_RK_RESET, $past(vector_base_low_group) + IVP_OFS_RESET))
        else $error("reset request not served first at offset zero");

    chk_low_vector_spacing: assert property (
        take && !ivp_is_high(sel_num)
        |=> irq_vector_addr == $past(vector_base_low_group) + {16'h0000, $past(sel_num), 3'h0})
        else $error("low-group vector address wrong");

    chk_high_vector_base: assert property (
        take && ivp_is_high(sel_num)
        |=> irq_vector_addr == $past(vector_base_high_group) + {16'h0000, $past(sel_num), 3'h0})
        else $error("high-group vector address wrong");

    chk_rank_table: assert property (
        irq_valid |-> (irq_rank == IVP_RANK[irq_number]) && (irq_rank <= IVP_RK_RTOS))
        else $error("offered rank does not match table");

    chk_no_src_quiet: assert property (
        (!r_q.swp[IVP_NUM_NO_SOURCE] && !sw_set[IVP_NUM_NO_SOURCE])
        |=> !(r_q.pend[IVP_NUM_NO_SOURCE] && !r_q.swp[IVP_NUM_NO_SOURCE]))
        else $error("hardware request raised for unassigned number");

    chk_offer_holds: assert property (
        irq_valid && !(ce && irq_ack) |=> irq_valid && $stable(irq_number) && $stable(irq_vector_addr))
        else $error("offer changed before acknowledge");

    chk_ack_clears: assert property (
        irq_valid && irq_ack && ce && !hw_set[irq_number] && !sw_set[irq_number]
        |=> !irq_valid && !r_q.pend[$past(irq_number)])
        else $error("acknowledge did not retire the interrupt");

    chk_set_wins: assert property (
        irq_valid && irq_ack && ce && hw_set[irq_number] |=> r_q.pend[$past(irq_number)])
        else $error("new request lost on acknowledge");

    chk_ext_irq_a: assert property (
        p_map_low(IVP_NUM_EXT_IRQ_A, IVP_RK_EXT_IRQ_A, IVP_OFS_EXT_IRQ_A))
        else $error("external interrupt A mapped wrong");

    chk_ext_irq_b: assert property (
        p_map_low(IVP_NUM_EXT_IRQ_B, IVP_RK_EXT_IRQ_B, IVP_OFS_EXT_IRQ_B))
        else $error("external interrupt B mapped wrong");

    chk_tx_port0: assert property (
        p_map_low(IVP_NUM_SHARED_TX_P0, IVP_RK_SHARED_TX_P0, IVP_OFS_SHARED_TX_P0))
        else $error("shared transmit port 0 mapped wrong");

    chk_rx_port0: assert property (
        p_map_low(IVP_NUM_SHARED_RX_P0, IVP_RK_SHARED_RX_P0, IVP_OFS_SHARED_RX_P0))
        else $error("shared receive port 0 mapped wrong");

    chk_tx_port1: assert property (
        p_map_low(IVP_NUM_SHARED_TX_P1, IVP_RK_SHARED_TX_P1, IVP_OFS_SHARED_TX_P1))
        else $error("shared transmit port 1 mapped wrong");

    chk_rx_port1: assert property (
        p_map_low(IVP_NUM_SHARED_RX_P1, IVP_RK_SHARED_RX_P1, IVP_OFS_SHARED_RX_P1))
        else $error("shared receive port 1 mapped wrong");

    chk_conv_done: assert property (
        p_map_low(IVP_NUM_CONV_DONE, IVP_RK_CONV_DONE, IVP_OFS_CONV_DONE))
        else $error("conversion done mapped wrong");

    chk_wakeup_rtc: assert property (
        p_map_high(IVP_NUM_WAKEUP_RTC, IVP_RK_WAKEUP_RTC, IVP_OFS_WAKEUP_RTC))
        else $error("wakeup interrupt mapped wrong");

    chk_rtos_lowest: assert property (
        p_map_low(IVP_NUM_RTOS, IVP_RK_RTOS, IVP_OFS_RTOS))
        else $error("operating system interrupt mapped wrong");

    chk_freeze_ce: assert property (
        !ce |=> $stable(r_q))
        else $error("state moved while clock enable low");

    chk_ack_gap: assert property (
        s_ack_edge |=> !irq_valid)
        else $error("offer did not drop after acknowledge");

    chk_next_offer: assert property (
        s_ack_edge ##1 (ce && sel_any) |=> irq_valid)
        else $error("next winner not offered after idle cycle");

    chk_no_src_trap: assert property (
        irq_valid && (irq_number == IVP_NUM_NO_SOURCE) |-> r_q.swp[IVP_NUM_NO_SOURCE])
        else $error("unassigned number offered without a trap");

    chk_reset_unmaskable: assert property (
        (r_q.st == IVP_IDLE) && ce && r_q.pend[IVP_NUM_RESET]
        |=> irq_valid && (irq_number == IVP_NUM_RESET))
        else $error("pending reset request not offered next");

    chk_idle_quiet: assert property (
        (r_q.st == IVP_IDLE) && !sel_any |=> !irq_valid)
        else $error("offer raised with no candidate");

    chk_rank_at_take: assert property (
        take |-> (sel_rank == IVP_RANK[sel_num]) && cand[sel_num])
        else $error("selected rank does not match table");

    chk_trap_set_wins: assert property (
        s_ack_edge && sw_set[irq_number] |=> r_q.swp[$past(irq_number)])
        else $error("new trap lost on acknowledge");

    chk_offer_pending: assert property (
        irq_valid |-> r_q.pend[irq_number])
        else $error("offered interrupt is not pending");

    chk_enable_mask: assert property (
        take
        |-> irq_enable[sel_num] || (sel_num == IVP_NUM_RESET) || r_q.swp[sel_num])
        else $error("disabled interrupt selected");

    chk_rank_holds: assert property (
        irq_valid && !(ce && irq_ack) |=> $stable(irq_rank))
        else $error("offered rank changed before acknowledge");

    chk_no_src_hw: assert property (
        ce && !sw_set[IVP_NUM_NO_SOURCE] && !r_q.pend[IVP_NUM_NO_SOURCE]
        |=> !r_q.pend[IVP_NUM_NO_SOURCE])
        else $error("hardware request set pending for unassigned number");

endmodule : ivp_map

// [sim/ivp_core_model.sv]
// Core-side partner model that accepts offers after a set wait
module ivp_core_model
    import ivp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // Offer from the mapper
    input wire logic irq_valid,
    input wire logic [4:0] irq_number,
    input wire logic [4:0] irq_rank,
    input wire logic [23:0] irq_vector_addr,
    output logic irq_ack,
    // Wait setting and record of the last accepted offer
    input wire logic [3:0] ack_wait,
    output logic [4:0] got_num,
    output logic [4:0] got_rank,
    output logic [23:0] got_vec,
    output int got_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    int wait_cnt;
    // Ack changes only after a falling edge and holds until the sampling edge
    always @(negedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            irq_ack <= 1'b0;
            wait_cnt <= 0;
        end
        else
        begin
            irq_ack <= irq_valid && (wait_cnt >= int'(ack_wait));
            wait_cnt <= irq_valid ? wait_cnt + 1 : 0;
        end
    end
    // Takes the offer at an enabled edge where valid and ack are both high
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            got_num <= 5'h00;
            got_rank <= 5'h00;
            got_vec <= 24'h000000;
            got_cnt <= 0;
        end
        else if (ce && irq_valid && irq_ack)
        begin
            got_num <= irq_number;
            got_rank <= irq_rank;
            got_vec <= irq_vector_addr;
            got_cnt <= got_cnt + 1;
        end
    end
endmodule : ivp_core_model

// [sim/tb_interrupt_vector_priority_map.sv]
// Testbench for the interrupt vector and priority mapper
module tb_interrupt_vector_priority_map
    import ivp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NT = 15;
    localparam logic [4:0] T_NUM [NT] = '{5'h00, 5'h02, 5'h03, 5'h05, 5'h07, 5'h09, 5'h0B,
        5'h0D, 5'h12, 5'h1A, 5'h0F, 5'h10, 5'h17, 5'h18, 5'h1F};
    localparam logic [7:0] T_OFS [NT] = '{8'h00, 8'h10, 8'h18, 8'h28, 8'h38, 8'h48, 8'h58,
        8'h68, 8'h90, 8'hD0, 8'h78, 8'h80, 8'hB8, 8'hC0, 8'hF8};
    localparam logic [4:0] T_RK [NT] = '{5'h00, 5'h03, 5'h05, 5'h07, 5'h0A, 5'h0D, 5'h0F,
        5'h12, 5'h0C, 5'h1A, 5'h16, 5'h04, 5'h18, 5'h02, 5'h12};
    logic clk, nrst, ce, sw_trap_valid, irq_valid, irq_ack;
    logic [31:0] hw_irq_req, irq_enable;
    logic [4:0] software_trap_number, irq_number, irq_rank, got_num, got_rank;
    logic [23:0] base_lo, base_hi, irq_vector_addr, got_vec;
    logic [3:0] ack_wait;
    int got_cnt, err_count, cmp_count;

    ivp_map dut (.clk(clk), .nrst(nrst), .ce(ce), .hw_irq_req(hw_irq_req),
        .irq_enable(irq_enable), .sw_trap_valid(sw_trap_valid),
        .software_trap_number(software_trap_number), .vector_base_low_group(base_lo),
        .vector_base_high_group(base_hi), .irq_valid(irq_valid), .irq_ack(irq_ack),
        .irq_number(irq_number), .irq_rank(irq_rank), .irq_vector_addr(irq_vector_addr));
    ivp_core_model core (.clk(clk), .nrst(nrst), .ce(ce), .irq_valid(irq_valid),
        .irq_number(irq_number), .irq_rank(irq_rank), .irq_vector_addr(irq_vector_addr),
        .irq_ack(irq_ack), .ack_wait(ack_wait), .got_num(got_num), .got_rank(got_rank),
        .got_vec(got_vec), .got_cnt(got_cnt));

    task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // One-cycle request, entered at a falling edge
    task automatic raise(input logic [31:0] hw, input logic trap, input logic [4:0] num);
        hw_irq_req = hw;
        sw_trap_valid = trap;
        software_trap_number = num;
        @(negedge clk);
        hw_irq_req = 32'h00000000;
        sw_trap_valid = 1'b0;
    endtask : raise

    // Waits for the next accepted offer and judges it
    task automatic expect_offer(input logic [4:0] num, input logic [4:0] rk,
        input logic [23:0] ofs);
        int n0;
        int k;
        n0 = got_cnt;
        k = 0;
        while (got_cnt == n0 && k < 60)
        begin
            @(negedge clk);
            k++;
        end
        check(24'(got_cnt - n0), 24'h000001, "offer count");
        check({19'h0, got_num}, {19'h0, num}, "number");
        check({19'h0, got_rank}, {19'h0, rk}, "rank");
        check(got_vec, ((num >= 5'h10 && num <= 5'h17) ? base_hi : base_lo) + ofs, "vector");
    endtask : expect_offer

    // Quiet span: no offer and no acceptance
    task automatic expect_quiet();
        int n0;
        n0 = got_cnt;
        repeat (12) @(negedge clk);
        check(24'(got_cnt - n0), 24'h000000, "unexpected offer");
        check({23'h0, irq_valid}, 24'h000000, "valid while quiet");
    endtask : expect_quiet

    task automatic test_table();
        ack_wait = 4'h0;
        for (int i = 0; i < NT; i++)
        begin
            raise(i[0] ? 32'h0 : (32'h1 << T_NUM[i]), i[0], T_NUM[i]);
            expect_offer(T_NUM[i], T_RK[i], {16'h0000, T_OFS[i]});
        end
    endtask : test_table

    task automatic test_priority();
        ack_wait = 4'h5;
        raise(32'h05040084, 1'b0, 5'h00);
        expect_offer(5'h18, 5'h02, 24'h0000C0);
        expect_offer(5'h02, 5'h03, 24'h000010);
        expect_offer(5'h07, 5'h0A, 24'h000038);
        expect_offer(5'h12, 5'h0C, 24'h000090);
        expect_offer(5'h1A, 5'h1A, 24'h0000D0);
    endtask : test_priority

    task automatic test_blocked();
        ack_wait = 4'h0;
        irq_enable[5] = 1'b0;
        raise(32'h00400020, 1'b0, 5'h00);
        expect_quiet();
        irq_enable[5] = 1'b1;
        expect_offer(5'h05, 5'h07, 24'h000028);
        expect_quiet();
    endtask : test_blocked

    // Clock enable low holds a pending request back
    task automatic test_freeze();
        ack_wait = 4'h0;
        raise(32'h00000200, 1'b0, 5'h00);
        ce = 1'b0;
        expect_quiet();
        ce = 1'b1;
        expect_offer(5'h09, 5'h0D, 24'h000048);
    endtask : test_freeze

    // Reset and traps pass cleared enables; a request held over the ack comes again
    task automatic test_masks();
        irq_enable = 32'h00000000;
        raise(32'h00000001, 1'b0, 5'h00);
        expect_offer(5'h00, 5'h00, 24'h000000);
        raise(32'h00000000, 1'b1, 5'h07);
        expect_offer(5'h07, 5'h0A, 24'h000038);
        irq_enable = 32'hFFFFFFFF;
        hw_irq_req = 32'h00002000;
        expect_offer(5'h0D, 5'h12, 24'h000068);
        hw_irq_req = 32'h00000000;
        expect_offer(5'h0D, 5'h12, 24'h000068);
        expect_quiet();
    endtask : test_masks

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        err_count++;
        $display("ERROR t=%0t watchdog expired", $time);
        end_of_test();
    end

    initial
    begin
        nrst = 1'b0;
        ce = 1'b1;
        hw_irq_req = 32'h00000000;
        irq_enable = 32'hFFFFFFFF;
        sw_trap_valid = 1'b0;
        software_trap_number = 5'h00;
        base_lo = 24'h012300;
        base_hi = 24'h0ABC00;
        ack_wait = 4'h0;
        err_count = 0;
        cmp_count = 0;
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        test_table();
        test_priority();
        test_blocked();
        test_freeze();
        test_masks();
        end_of_test();
    end
endmodule : tb_interrupt_vector_priority_map
